// >>> hdl/rtc_cfg.svh
// Constants for the bus port and calendar: addresses, fields, reset values and timing counts.
`ifndef RTC_CFG_SVH
`define RTC_CFG_SVH

// ************************************************************
// Register addresses
// ************************************************************
`define RTC_A_SEC_UNITS   4'h0
`define RTC_A_SEC_TENS    4'h1
`define RTC_A_MIN_UNITS   4'h2
`define RTC_A_MIN_TENS    4'h3
`define RTC_A_HOUR_UNITS  4'h4
`define RTC_A_HOUR_TENS   4'h5
`define RTC_A_DATE_UNITS  4'h6
`define RTC_A_DATE_TENS   4'h7
`define RTC_A_MONTH_UNITS 4'h8
`define RTC_A_MONTH_TENS  4'h9
`define RTC_A_YEAR_UNITS  4'ha
`define RTC_A_YEAR_TENS   4'hb
`define RTC_A_WEEKDAY     4'hc
`define RTC_A_CTRL_F      4'hf
`define RTC_NUM_TIME_REGS 13

// ************************************************************
// Field positions
// ************************************************************
`define RTC_HT_TWENTY_BIT 1
`define RTC_HT_PM_BIT     2
`define RTC_F_MODE24_BIT  2

// ************************************************************
// Reset values (00:00:00, hours read 00 in 12-hour view as well, 01-01-00, day 0)
// ************************************************************
`define RTC_RST_DATE_UNITS  4'h1
`define RTC_RST_MONTH_UNITS 4'h1

// ************************************************************
// Timing
// ************************************************************
`define RTC_OSC_HZ        32768
`define RTC_STD_LOW_NS    7812500
`define RTC_STD_LOW_OSC   ((`RTC_STD_LOW_NS * 64'd32768) / 64'd1000000000)

`endif

// >>> hdl/rtc_pkg.sv
// Shared types of the bus port and calendar.
package rtc_pkg;

   typedef logic [3:0] rtc_nib_t;

   typedef enum logic [1:0]
   {
      RTC_PS_IDLE = 2'b01,
      RTC_PS_LOW  = 2'b10
   } rtc_pulse_st_t;

endpackage

// >>> hdl/rtc_tick_if.sv
// Time base signals passed from the divider to the calendar.
`timescale 1ns/1ps
interface rtc_tick_if;
   logic osc_edge;  // One cycle per oscillator rising edge.
   logic sec_tick;  // One cycle per second.

   modport src
   (
      output osc_edge,
      output sec_tick
   );
   modport dst
   (
      input  osc_edge,
      input  sec_tick
   );
endinterface

// >>> hdl/rtc_sec_div.sv
// Divides the sampled oscillator pin down to a one-second tick.
`timescale 1ns/1ps
`include "rtc_cfg.svh"
module rtc_sec_div
#(
   parameter int OSC_HZ = `RTC_OSC_HZ
)
(
   input  wire logic clk_i,    // System clock.
   input  wire logic reset_i,  // Asynchronous reset, active high.
   input  wire logic osc_pin_i, // Oscillator level, synchronous.
   rtc_tick_if.src   tick      // Tick outputs.
);

   logic        osc_q;
   logic [15:0] div_q;
   logic        edge_w;

   assign edge_w = osc_pin_i & ~osc_q;

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
         osc_q <= 1'b0;
      else
         osc_q <= osc_pin_i;
   end

   // ************************************************************
   // Prescaler
   // ************************************************************
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
         div_q <= 16'h0000;
      else if (edge_w)
         div_q <= (div_q == 16'(OSC_HZ - 1)) ? 16'h0000 : div_q + 16'h0001;
   end

   assign tick.osc_edge = edge_w;
   assign tick.sec_tick = edge_w && (div_q == 16'(OSC_HZ - 1));

endmodule // rtc_sec_div

// >>> hdl/rtc_bus_port.sv
// Parallel bus port and BCD calendar of the real time clock.
// ************************************************************
// What this block does
// - Four-bit two-way data bus, bit 0 LSB.
// - Four address inputs pick the register.
// - Latch passes address when enabled, else holds.
// - Selected write to 0 to C stores nibble on strobe rise.
// - Selected read drives register onto data bus.
// - Both strobes low suppresses the read.
// - Both chip selects gate read and write; low select alone gates latch.
// - Open-drain low pulse output, mode by control.
// - Time registers hold BCD values.
// - Bits weigh 8,4,2,1, positive logic.
// - 24-hour mode: afternoon flag reads zero.
// - 12-hour mode: bit twenty reads zero unless written.
// - Automatic leap year from two year digits.
// - Impossible date becomes first of next month.
// - Weekday counts 0 to 6, wraps.
// - Mode bit selects 24 or 12 hours.
// - Time registers sit at addresses 0 to C.
// ************************************************************
`timescale 1ns/1ps
`include "rtc_cfg.svh"
module rtc_bus_port
#(
   parameter int OSC_HZ  = `RTC_OSC_HZ,
   parameter int STD_LOW = 256
)
(
   input  wire logic       clk_i,              // System clock, 200 MHz.
   input  wire logic       reset_i,            // Asynchronous reset, active high.
   input  wire logic [3:0] addr_i,             // Register address.
   input  wire logic       ale_i,              // Address latch enable.
   input  wire logic       chip_sel_low_active_n_i, // Select, active low.
   input  wire logic       chip_sel_high_active_i,  // Select, active high.
   input  wire logic       rd_n_i,             // Read strobe, active low.
   input  wire logic       wr_n_i,             // Write strobe, active low.
   input  wire logic [3:0] data_i,             // Data bus level in.
   output logic      [3:0] data_o,             // Data bus drive value.
   output logic            data_oe_o,          // Data bus drive enable.
   input  wire logic       osc_pin_i,          // Oscillator level.
   input  wire logic       hour_mode_24_i,     // 1 selects 24-hour counting.
   input  wire logic       pulse_irq_mode_i,   // 1 interrupt, 0 fixed pulse.
   input  wire logic       pulse_irq_clear_i,  // Ends a held interrupt.
   output logic            pulse_irq_out_o,    // Open-drain pin value, always 0.
   output logic            pulse_irq_out_oe_o  // High while pin pulled low.
);

   rtc_tick_if tick();

   rtc_sec_div #(.OSC_HZ(OSC_HZ)) u_div
   (
      .clk_i     (clk_i),
      .reset_i   (reset_i),
      .osc_pin_i (osc_pin_i),
      .tick      (tick)
   );

   rtc_pkg::rtc_nib_t   regs_q [0:`RTC_NUM_TIME_REGS-1];
   rtc_pkg::rtc_nib_t   nxt    [0:`RTC_NUM_TIME_REGS-1];
   logic [3:0]          addr_q;
   logic [3:0]          eff_addr;
   logic                wr_n_q;
   logic                sel;
   logic                wr_pulse;
   logic                mode24_q;

   function automatic logic [6:0] to_bin(input logic [3:0] t, input logic [3:0] u);
      to_bin = 7'(t * 4'd10) + 7'(u);
   endfunction

   function automatic logic [7:0] to_bcd(input logic [6:0] b);
      to_bcd = {4'(b / 7'd10), 4'(b % 7'd10)};
   endfunction

   // ************************************************************
   // Bus port
   // ************************************************************
   assign sel = chip_sel_high_active_i && !chip_sel_low_active_n_i;
   assign eff_addr = (ale_i && !chip_sel_low_active_n_i) ? addr_i : addr_q;
   assign wr_pulse = sel && !wr_n_q && wr_n_i;

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
         addr_q <= 4'h0;
      else if (ale_i && !chip_sel_low_active_n_i)
         addr_q <= addr_i;
   end

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
         wr_n_q <= 1'b1;
      else
         wr_n_q <= wr_n_i;
   end

   // Drive only when selected and the write strobe is idle.
   assign data_oe_o = sel && !rd_n_i && wr_n_i;

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
         data_o <= 4'h0;
      else if (eff_addr == `RTC_A_HOUR_TENS)
      begin
         data_o <= regs_q[`RTC_A_HOUR_TENS];
         if (mode24_q)
            data_o[`RTC_HT_PM_BIT] <= 1'b0;
      end
      else if (eff_addr < 4'(`RTC_NUM_TIME_REGS))
         data_o <= regs_q[eff_addr];
      else if (eff_addr == `RTC_A_CTRL_F)
         data_o <= {1'b0, mode24_q, 2'b00};
      else
         data_o <= 4'h0;
   end

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
         mode24_q <= 1'b0;
      else
         mode24_q <= hour_mode_24_i;
   end

   // ************************************************************
   // Calendar counting
   // ************************************************************
   logic [6:0] sec_b, min_b, hr_b, date_b, mon_b, yr_b, dim, hr_n;
   logic       c_min, c_hr, c_day, c_mon, pm_n;

   always_comb
   begin
      for (int i = 0; i < `RTC_NUM_TIME_REGS; i++)
         nxt[i] = regs_q[i];
      sec_b  = to_bin(regs_q[`RTC_A_SEC_TENS], regs_q[`RTC_A_SEC_UNITS]);
      min_b  = to_bin(regs_q[`RTC_A_MIN_TENS], regs_q[`RTC_A_MIN_UNITS]);
      hr_b   = to_bin({2'b00, regs_q[`RTC_A_HOUR_TENS][1:0]}, regs_q[`RTC_A_HOUR_UNITS]);
      date_b = to_bin(regs_q[`RTC_A_DATE_TENS], regs_q[`RTC_A_DATE_UNITS]);
      mon_b  = to_bin(regs_q[`RTC_A_MONTH_TENS], regs_q[`RTC_A_MONTH_UNITS]);
      yr_b   = to_bin(regs_q[`RTC_A_YEAR_TENS], regs_q[`RTC_A_YEAR_UNITS]);
      pm_n   = regs_q[`RTC_A_HOUR_TENS][`RTC_HT_PM_BIT];
      // Year 00 counts as leap, which holds for the current century.
      if (mon_b == 7'd2)
         dim = (yr_b[1:0] == 2'b00) ? 7'd29 : 7'd28;
      else if (mon_b == 7'd4 || mon_b == 7'd6 || mon_b == 7'd9 || mon_b == 7'd11)
         dim = 7'd30;
      else
         dim = 7'd31;
      c_min = sec_b >= 7'd59;
      c_hr  = c_min && (min_b >= 7'd59);
      if (mode24_q)
      begin
         c_day = c_hr && (hr_b >= 7'd23);
         hr_n  = c_day ? 7'd0 : hr_b + 7'd1;
      end
      else
      begin
         c_day = c_hr && (hr_b == 7'd11) && pm_n;
         hr_n  = (hr_b >= 7'd12) ? 7'd1 : hr_b + 7'd1;
      end
      // A date at or past month end, real or not, moves to the 1st.
      c_mon = c_day && (date_b >= dim);
      if (tick.sec_tick)
      begin
         {nxt[`RTC_A_SEC_TENS], nxt[`RTC_A_SEC_UNITS]} =
            to_bcd(c_min ? 7'd0 : sec_b + 7'd1);
         if (c_min)
            {nxt[`RTC_A_MIN_TENS], nxt[`RTC_A_MIN_UNITS]} =
               to_bcd(c_hr ? 7'd0 : min_b + 7'd1);
         if (c_hr)
         begin
            {nxt[`RTC_A_HOUR_TENS], nxt[`RTC_A_HOUR_UNITS]} = to_bcd(hr_n);
            if (!mode24_q)
               nxt[`RTC_A_HOUR_TENS][`RTC_HT_PM_BIT] = (hr_b == 7'd11) ? !pm_n : pm_n;
         end
         if (c_day)
         begin
            {nxt[`RTC_A_DATE_TENS], nxt[`RTC_A_DATE_UNITS]} =
               to_bcd(c_mon ? 7'd1 : date_b + 7'd1);
            nxt[`RTC_A_WEEKDAY] = (regs_q[`RTC_A_WEEKDAY] >= 4'h6) ? 4'h0 :
                                  regs_q[`RTC_A_WEEKDAY] + 4'h1;
         end
         if (c_mon)
         begin
            {nxt[`RTC_A_MONTH_TENS], nxt[`RTC_A_MONTH_UNITS]} =
               to_bcd((mon_b >= 7'd12) ? 7'd1 : mon_b + 7'd1);
            if (mon_b >= 7'd12)
               {nxt[`RTC_A_YEAR_TENS], nxt[`RTC_A_YEAR_UNITS]} =
                  to_bcd((yr_b >= 7'd99) ? 7'd0 : yr_b + 7'd1);
         end
      end
      // Values are stored unchecked; out-of-range writes count oddly.
      if (wr_pulse && eff_addr < 4'(`RTC_NUM_TIME_REGS))
         nxt[eff_addr] = data_i;
      // Entering 12-hour mode clears bit twenty until the host rewrites it.
      if (mode24_q && !hour_mode_24_i)
         nxt[`RTC_A_HOUR_TENS][`RTC_HT_TWENTY_BIT] = 1'b0;
   end

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         for (int i = 0; i < `RTC_NUM_TIME_REGS; i++)
            regs_q[i] <= 4'h0;
         regs_q[`RTC_A_DATE_UNITS]  <= `RTC_RST_DATE_UNITS;
         regs_q[`RTC_A_MONTH_UNITS] <= `RTC_RST_MONTH_UNITS;
      end
      else
      begin
         for (int i = 0; i < `RTC_NUM_TIME_REGS; i++)
            regs_q[i] <= nxt[i];
      end
   end

   // ************************************************************
   // Pulse and interrupt output
   // ************************************************************
   rtc_pkg::rtc_pulse_st_t ps_q;
   logic [15:0]            low_cnt_q;

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         ps_q      <= rtc_pkg::RTC_PS_IDLE;
         low_cnt_q <= 16'h0000;
      end
      else
      begin
         case (ps_q)
            rtc_pkg::RTC_PS_IDLE:
               if (tick.sec_tick)
               begin
                  ps_q      <= rtc_pkg::RTC_PS_LOW;
                  low_cnt_q <= 16'h0000;
               end
            rtc_pkg::RTC_PS_LOW:
            begin
               // Selects play no part here: the pin runs while deselected.
               if (pulse_irq_clear_i)
                  ps_q <= rtc_pkg::RTC_PS_IDLE;
               else if (!pulse_irq_mode_i && tick.osc_edge)
               begin
                  low_cnt_q <= low_cnt_q + 16'h0001;
                  if (low_cnt_q == 16'(STD_LOW - 1))
                     ps_q <= rtc_pkg::RTC_PS_IDLE;
               end
            end
            default:
               ps_q <= rtc_pkg::RTC_PS_IDLE;
         endcase
      end
   end

   assign pulse_irq_out_o    = 1'b0;
   assign pulse_irq_out_oe_o = (ps_q == rtc_pkg::RTC_PS_LOW);

endmodule // rtc_bus_port

// >>> sim/rtc_bus_port_monitor.sv
// Port-level assertions for the bus port and calendar.
`timescale 1ns/1ps
`include "rtc_cfg.svh"
module rtc_bus_port_monitor
#(
   parameter int OSC_HZ  = 32768,
   parameter int STD_LOW = 256
)
(
   input wire logic       clk_i,                   // Clock.
   input wire logic       reset_i,                 // Reset.
   input wire logic [3:0] addr_i,                  // Address.
   input wire logic       ale_i,                   // Latch enable.
   input wire logic       chip_sel_low_active_n_i, // Select, low.
   input wire logic       chip_sel_high_active_i,  // Select, high.
   input wire logic       rd_n_i,                  // Read strobe.
   input wire logic       wr_n_i,                  // Write strobe.
   input wire logic [3:0] data_i,                  // Bus level.
   input wire logic [3:0] data_o,                  // Read data.
   input wire logic       data_oe_o,               // Bus drive.
   input wire logic       osc_pin_i,               // Oscillator.
   input wire logic       hour_mode_24_i,          // Hour mode.
   input wire logic       pulse_irq_mode_i,        // Pulse mode.
   input wire logic       pulse_irq_clear_i,       // Pulse clear.
   input wire logic       pulse_irq_out_o,         // Pin value.
   input wire logic       pulse_irq_out_oe_o       // Pin pull.
);
   // Flow-through address: the registered read data then follows addr_i one clock later.
   logic sel_w;
   logic ds_w;
   assign sel_w = chip_sel_high_active_i && !chip_sel_low_active_n_i;
   assign ds_w  = ale_i && !chip_sel_low_active_n_i;
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (reset_i);
   a_read_drive_on: assert property (sel_w && !rd_n_i && wr_n_i |-> data_oe_o)
      else $error("selected read not driven");
   a_strobe_clash_quiet: assert property (!rd_n_i && !wr_n_i |-> !data_oe_o)
      else $error("bus driven with both strobes low");
   a_deselect_quiet: assert property (!chip_sel_high_active_i |-> !data_oe_o)
      else $error("bus driven while deselected");
   a_low_sel_quiet: assert property (chip_sel_low_active_n_i |-> !data_oe_o)
      else $error("bus driven while low select off");
   a_pin_drive_low: assert property (pulse_irq_out_o == 1'b0)
      else $error("pulse pin value not low");
   a_irq_pulse_held: assert property (pulse_irq_out_oe_o && pulse_irq_mode_i &&
      !pulse_irq_clear_i && !$past(pulse_irq_clear_i) |=> pulse_irq_out_oe_o)
      else $error("interrupt output released without clear");
   a_clear_ends_pulse: assert property ($rose(pulse_irq_clear_i) |->
      ##[1:3] !pulse_irq_out_oe_o) else $error("clear did not release pin");
   a_mode_reads_back: assert property ((ds_w && addr_i == `RTC_A_CTRL_F &&
      $stable(hour_mode_24_i)) [*3] |-> data_o == {1'b0, hour_mode_24_i, 2'b00})
      else $error("mode bit read wrong");
   a_pm_reads_zero: assert property ((ds_w && addr_i == `RTC_A_HOUR_TENS &&
      hour_mode_24_i) [*3] |-> !data_o[2]) else $error("afternoon bit read in 24h");
   a_weekday_range: assert property ((ds_w && addr_i == `RTC_A_WEEKDAY) [*3]
      |-> data_o <= 4'h6) else $error("weekday out of range");
   a_gap_reads_zero: assert property ((ds_w && (addr_i == 4'hd || addr_i == 4'he))
      [*3] |-> data_o == 4'h0) else $error("unmapped address not zero");
endmodule // rtc_bus_port_monitor

// >>> sim/rtc_host_model.sv
// Host bus model: drives address, latch, select and strobes, resolves the data wire.
`timescale 1ns/1ps
module rtc_host_model
(
   input  wire logic       clk_i,     // Clock.
   input  wire logic [3:0] rd_data_i, // Device read data.
   input  wire logic       rd_oe_i,   // Device drives bus.
   output logic      [3:0] addr_o,    // Address.
   output logic            ale_o,     // Latch enable.
   output logic            hi_sel_o,  // Select, active high.
   output logic            rd_n_o,    // Read strobe.
   output logic            wr_n_o,    // Write strobe.
   output logic      [3:0] bus_o      // Resolved data wire.
);
   logic [3:0] drv_q = 4'h0;
   logic       drv_en_q = 1'b0;
   logic [3:0] last_q = 4'h0;
   // Nothing pulls the wire, so a released bus shows the inverse of its last level.
   assign bus_o = rd_oe_i ? rd_data_i : (drv_en_q ? drv_q : ~last_q);
   always @(posedge clk_i) last_q <= bus_o;
   initial
   begin
      addr_o   = 4'h0;
      ale_o    = 1'b1;
      hi_sel_o = 1'b1;
      rd_n_o   = 1'b1;
      wr_n_o   = 1'b1;
   end
   task automatic bus_write(input logic [3:0] a, input logic [3:0] d, input logic hi);
      @(negedge clk_i);
      addr_o   = a;
      hi_sel_o = hi;
      drv_q    = d;
      drv_en_q = 1'b1;
      wr_n_o   = 1'b0;
      @(negedge clk_i);
      wr_n_o = 1'b1;
      @(negedge clk_i);
      drv_en_q = 1'b0;
      hi_sel_o = 1'b1;
   endtask
   task automatic bus_read(input logic [3:0] a, input logic latch, output logic [3:0] d);
      @(negedge clk_i);
      addr_o = a;
      if (latch)
      begin
         @(negedge clk_i);
         ale_o  = 1'b0;
         addr_o = ~a;
      end
      rd_n_o = 1'b0;
      repeat (2) @(negedge clk_i);
      d      = bus_o;
      rd_n_o = 1'b1;
      ale_o  = 1'b1;
   endtask
   // Deselect in the same step as raising the write strobe so the clash stores nothing.
   task automatic strobe_clash(output logic oe);
      @(negedge clk_i);
      rd_n_o = 1'b0;
      wr_n_o = 1'b0;
      @(negedge clk_i);
      oe       = rd_oe_i;
      hi_sel_o = 1'b0;
      rd_n_o   = 1'b1;
      wr_n_o   = 1'b1;
      @(negedge clk_i);
      hi_sel_o = 1'b1;
   endtask
endmodule // rtc_host_model

// >>> sim/testbench.sv
// Self-checking bench for the bus port and calendar.
`timescale 1ns/1ps
module testbench;
   localparam int OSC_HZ  = 8;
   localparam int STD_LOW = 2;
   localparam logic [51:0] INIT [4] = '{52'h6010228235959, 52'h2040228235959,
                                       52'h0851131235959, 52'h4991231235959};
   localparam logic [51:0] EXPT [4] = '{52'h0010301000000, 52'h3040229000000,
                                       52'h1851201000000, 52'h5000101000000};
   logic       clk_i = 1'b0;
   logic       reset_i = 1'b1;
   logic [3:0] addr, bus, dout, d;
   logic       ale, hi, rd_n, wr_n, doe, pin, pin_oe, oe;
   logic       lo_n = 1'b0;
   logic       osc = 1'b0;
   logic       m24 = 1'b1;
   logic       imode = 1'b0;
   logic       iclr = 1'b0;
   int         num_errors = 0;
   int         check_count = 0;
   int         cycles = 0;
   always #2.5 clk_i = ~clk_i;
   rtc_bus_port #(.OSC_HZ(OSC_HZ), .STD_LOW(STD_LOW)) rtc_bus_port_i (.clk_i(clk_i),
      .reset_i(reset_i), .addr_i(addr), .ale_i(ale), .chip_sel_low_active_n_i(lo_n),
      .chip_sel_high_active_i(hi), .rd_n_i(rd_n), .wr_n_i(wr_n), .data_i(bus),
      .data_o(dout), .data_oe_o(doe), .osc_pin_i(osc), .hour_mode_24_i(m24),
      .pulse_irq_mode_i(imode), .pulse_irq_clear_i(iclr), .pulse_irq_out_o(pin),
      .pulse_irq_out_oe_o(pin_oe));
   rtc_host_model host_i (.clk_i(clk_i), .rd_data_i(dout), .rd_oe_i(doe), .addr_o(addr),
      .ale_o(ale), .hi_sel_o(hi), .rd_n_o(rd_n), .wr_n_o(wr_n), .bus_o(bus));
   task automatic check(input logic [3:0] got, input logic [3:0] exp);
      check_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("BAD %0t got %h want %h", $time, got, exp);
      end
   endtask
   task automatic rd_chk(input logic [3:0] a, input logic [3:0] exp);
      logic [3:0] v;
      host_i.bus_read(a, 1'b0, v);
      check(v, exp);
   endtask
   task automatic wr_all(input logic [51:0] v);
      for (int i = 0; i < 13; i++) host_i.bus_write(i[3:0], v[4*i +: 4], 1'b1);
   endtask
   task automatic chk_all(input logic [51:0] v);
      for (int i = 0; i < 13; i++) rd_chk(i[3:0], v[4*i +: 4]);
   endtask
   task automatic osc_run(input int n);
      repeat (n)
      begin
         @(negedge clk_i) osc = 1'b1;
         repeat (4) @(negedge clk_i);
         osc = 1'b0;
         repeat (4) @(negedge clk_i);
      end
   endtask
   // The oscillator stands still between seconds so the divider phase stays known.
   task automatic tick(input int n);
      int w;
      osc_run(n);
      w = 0;
      while (pin_oe !== 1'b1 && w < 50)
      begin
         @(negedge clk_i);
         w++;
      end
      repeat (4) @(negedge clk_i);
      check({3'b000, pin_oe}, 4'h1);
   endtask
   task automatic clr();
      @(negedge clk_i) iclr = 1'b1;
      repeat (2) @(negedge clk_i);
      iclr = 1'b0;
      @(negedge clk_i);
      check({3'b000, pin_oe}, 4'h0);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   always @(posedge clk_i)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         num_errors++;
         $display("BAD %0t run too long", $time);
         tally_and_finish();
      end
   end
   initial
   begin
      repeat (20) @(negedge clk_i);
      reset_i = 1'b0;
      chk_all(52'h0000101000000);
      rd_chk(4'hf, 4'h4);
      rd_chk(4'hd, 4'h0);
      rd_chk(4'he, 4'h0);
      $display("test reset done");
      wr_all(52'h5981231194538);
      chk_all(52'h5981231194538);
      host_i.bus_read(4'h3, 1'b1, d);
      check(d, 4'h4);
      host_i.bus_write(4'h0, 4'h1, 1'b0);
      rd_chk(4'h0, 4'h8);
      lo_n = 1'b1;
      host_i.bus_write(4'h0, 4'h2, 1'b1);
      host_i.bus_read(4'h0, 1'b0, d);
      lo_n = 1'b0;
      rd_chk(4'h0, 4'h8);
      host_i.bus_write(4'hf, 4'h0, 1'b1);
      rd_chk(4'hf, 4'h4);
      host_i.strobe_clash(oe);
      check({3'b000, oe}, 4'h0);
      rd_chk(4'h0, 4'h8);
      $display("test access done");
      tick(OSC_HZ);
      osc_run(STD_LOW);
      check({3'b000, pin_oe}, 4'h0);
      tick(OSC_HZ - STD_LOW);
      clr();
      for (int k = 0; k < 4; k++)
      begin
         wr_all(INIT[k]);
         tick(OSC_HZ);
         chk_all(EXPT[k]);
         clr();
      end
      $display("test calendar done");
      host_i.bus_write(4'h5, 4'h2, 1'b1);
      @(negedge clk_i) m24 = 1'b0;
      repeat (3) @(negedge clk_i);
      rd_chk(4'h5, 4'h0);
      rd_chk(4'hf, 4'h0);
      wr_all(52'h0000101115959);
      tick(OSC_HZ);
      chk_all(52'h0000101520000);
      clr();
      @(negedge clk_i) m24 = 1'b1;
      repeat (3) @(negedge clk_i);
      rd_chk(4'h5, 4'h1);
      $display("test hour mode done");
      imode = 1'b1;
      tick(OSC_HZ);
      repeat (20) @(negedge clk_i);
      check({3'b000, pin_oe}, 4'h1);
      check({3'b000, pin}, 4'h0);
      clr();
      $display("test interrupt done");
      tally_and_finish();
   end
endmodule // testbench
bind rtc_bus_port rtc_bus_port_monitor #(.OSC_HZ(OSC_HZ), .STD_LOW(STD_LOW)) mon_i (
   .clk_i(clk_i), .reset_i(reset_i), .addr_i(addr_i), .ale_i(ale_i),
   .chip_sel_low_active_n_i(chip_sel_low_active_n_i),
   .chip_sel_high_active_i(chip_sel_high_active_i), .rd_n_i(rd_n_i), .wr_n_i(wr_n_i),
   .data_i(data_i), .data_o(data_o), .data_oe_o(data_oe_o), .osc_pin_i(osc_pin_i),
   .hour_mode_24_i(hour_mode_24_i), .pulse_irq_mode_i(pulse_irq_mode_i),
   .pulse_irq_clear_i(pulse_irq_clear_i), .pulse_irq_out_o(pulse_irq_out_o),
   .pulse_irq_out_oe_o(pulse_irq_out_oe_o));
